// file: gdsf_params.svh
`ifndef GDSF_PARAMS_SVH
`define GDSF_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define GDSF_OFF_DRIVE_SET   12'h518
`define GDSF_OFF_DRIVE_CLR   12'h51C
`define GDSF_OFF_SENSE_HIT   12'h520
// ==========================================================
// Reset values and widths
`define GDSF_RST_DIR         32'h0000_0000
`define GDSF_RST_HIT         32'h0000_0000
`define GDSF_ADDR_W          12
`define GDSF_DATA_W          32
`define GDSF_PINS            32
// Write strobe lanes
`define GDSF_LANE_W          8
`define GDSF_LANES           4
`endif

// file: gdsf_pkg.sv
`default_nettype none
`include "gdsf_params.svh"
package gdsf_pkg;
    // APB request as seen by the slave
    typedef struct packed {
        logic                      sel;
        logic                      enable;
        logic                      write;
        logic [`GDSF_ADDR_W-1:0]   addr;
        logic [`GDSF_DATA_W-1:0]   wdata;
    } gdsf_apb_req_t;
    // Register selected by an access
    typedef enum logic [1:0] {
        GDSF_REG_NONE,
        GDSF_REG_SET,
        GDSF_REG_CLR,
        GDSF_REG_HIT
    } gdsf_reg_sel_t;
endpackage
`default_nettype wire

// file: gdsf_gpio_regs.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "gdsf_params.svh"
module gdsf_gpio_regs #(
    parameter int PINS = `GDSF_PINS
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`GDSF_ADDR_W-1:0] paddr,
    input  wire logic [`GDSF_DATA_W-1:0] pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [`GDSF_DATA_W-1:0] prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Pin side
    input  wire logic [PINS-1:0]         criterion_hit,
    output logic      [PINS-1:0]         pin_dir_out,
    output logic      [PINS-1:0]         sense_hit_out
);

    // ==========================================================
    // Local constants
    // Byte lanes on the write bus; each lane gates one group of pins
    localparam int LANES = `GDSF_LANES;
    // Reset images cut to the pin count, so a narrower port resets cleanly
    localparam logic [`GDSF_DATA_W-1:0] DIR_RST_W = `GDSF_RST_DIR;
    localparam logic [`GDSF_DATA_W-1:0] HIT_RST_W = `GDSF_RST_HIT;
    localparam logic [PINS-1:0]         DIR_RST   = DIR_RST_W[PINS-1:0];
    localparam logic [PINS-1:0]         HIT_RST   = HIT_RST_W[PINS-1:0];

    // ==========================================================
    // Elaboration checks
    if (PINS < 1 || PINS > `GDSF_DATA_W) begin : g_bad_pins
        $error("PINS must be 1 to 32");
    end

    // The strobe fan-out assumes the data bus is whole lanes
    if (`GDSF_DATA_W != LANES * `GDSF_LANE_W) begin : g_bad_lanes
        $error("Data width must be a whole number of byte lanes");
    end

    // ==========================================================
    // Bus decode
    gdsf_pkg::gdsf_apb_req_t req;
    gdsf_pkg::gdsf_reg_sel_t reg_sel;
    wire logic               acc;
    wire logic               wr_acc;
    wire logic [PINS-1:0]    wmask;
    wire logic [PINS-1:0]    wbits;
    wire logic [`GDSF_DATA_W-1:0] strb_mask;
    wire logic               sel_set;
    wire logic               sel_clr;
    wire logic               sel_hit;

    assign req     = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign reg_sel = (req.addr == `GDSF_OFF_DRIVE_SET) ? gdsf_pkg::GDSF_REG_SET :
                     (req.addr == `GDSF_OFF_DRIVE_CLR) ? gdsf_pkg::GDSF_REG_CLR :
                     (req.addr == `GDSF_OFF_SENSE_HIT) ? gdsf_pkg::GDSF_REG_HIT :
                                                         gdsf_pkg::GDSF_REG_NONE;
    assign sel_set = (reg_sel == gdsf_pkg::GDSF_REG_SET);
    assign sel_clr = (reg_sel == gdsf_pkg::GDSF_REG_CLR);
    assign sel_hit = (reg_sel == gdsf_pkg::GDSF_REG_HIT);
    assign acc     = req.sel && req.enable;
    assign wr_acc  = acc && req.write;
    // Byte strobes gate which pins a write touches
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign strb_mask[l*`GDSF_LANE_W +: `GDSF_LANE_W] = {`GDSF_LANE_W{pstrb[l]}};
    end
    assign wmask   = strb_mask[PINS-1:0];
    assign wbits   = req.wdata[PINS-1:0] & wmask;

    // Zero wait states; unmapped offsets answer with an error and read zero
    assign pready  = 1'b1;
    assign pslverr = acc && (reg_sel == gdsf_pkg::GDSF_REG_NONE);

    // ==========================================================
    // Shared direction register
    logic [PINS-1:0] dir_q;
    logic [PINS-1:0] dir_d;
    wire logic [PINS-1:0] dir_set;
    wire logic [PINS-1:0] dir_clr;

    assign dir_set = (wr_acc && sel_set) ? wbits : '0;
    assign dir_clr = (wr_acc && sel_clr) ? wbits : '0;

    // Set and clear come from different offsets, so they never meet in one cycle
    for (genvar i = 0; i < PINS; i++) begin : g_dir
        assign dir_d[i] = (dir_q[i] | dir_set[i]) & ~dir_clr[i];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= DIR_RST;
        end else begin
            dir_q <= dir_d;
        end
    end

    // ==========================================================
    // Sticky sense-hit flags
    logic [PINS-1:0] hit_q;
    logic [PINS-1:0] hit_d;
    wire logic [PINS-1:0] hit_clr;

    assign hit_clr = (wr_acc && sel_hit) ? wbits : '0;

    // Per-pin: a hit in the clearing cycle keeps the flag set
    for (genvar i = 0; i < PINS; i++) begin : g_hit
        assign hit_d[i] = criterion_hit[i] | (hit_q[i] & ~hit_clr[i]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q <= HIT_RST;
        end else begin
            hit_q <= hit_d;
        end
    end

    // ==========================================================
    // Read data, pin n at bit n, upper bits zero
    logic [`GDSF_DATA_W-1:0] rdata_d;
    logic [`GDSF_DATA_W-1:0] rdata_q;
    wire logic               rd_setup;

    // Read data is registered in the setup cycle so it is stable in the access cycle
    assign rd_setup = req.sel && !req.enable && !req.write;

    always_comb begin
        rdata_d = '0;
        unique case (reg_sel)
            gdsf_pkg::GDSF_REG_SET: rdata_d[PINS-1:0] = dir_d;
            gdsf_pkg::GDSF_REG_CLR: rdata_d[PINS-1:0] = dir_d;
            gdsf_pkg::GDSF_REG_HIT: rdata_d[PINS-1:0] = hit_d;
            gdsf_pkg::GDSF_REG_NONE: rdata_d = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else if (rd_setup) begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata        = rdata_q;
    assign pin_dir_out   = dir_q;
    assign sense_hit_out = hit_q;

endmodule
`default_nettype wire

// file: gdsf_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Register checker
module gdsf_regs_chk #(parameter int PINS = 32) (
    // Clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // APB
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic [3:0]      pstrb,
    // Pin side
    input wire logic [PINS-1:0] criterion_hit,
    input wire logic [PINS-1:0] pin_dir_out,
    input wire logic [PINS-1:0] sense_hit_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr = acc && pwrite && pstrb == 4'hF;
    wire rd = acc && !pwrite;
    wire dw = acc && pwrite && (paddr == 12'h518 || paddr == 12'h51C);
    wire hw = acc && pwrite && paddr == 12'h520;
    sequence wr_at(a); wr && paddr == a; endsequence
    chk_dir_set: assert property (wr_at(12'h518) |=>
        pin_dir_out == ($past(pin_dir_out) | $past(pwdata))) else $error("set view");
    chk_dir_clr: assert property (wr_at(12'h51C) |=>
        pin_dir_out == ($past(pin_dir_out) & ~$past(pwdata))) else $error("clear view");
    chk_dir_hold: assert property (!dw |=> $stable(pin_dir_out))
        else $error("dir changed");
    chk_hit_stick: assert property (criterion_hit != 0 |=>
        (sense_hit_out & $past(criterion_hit)) == $past(criterion_hit)) else $error("hit lost");
    chk_hit_clear: assert property (wr_at(12'h520) |=> sense_hit_out ==
        ($past(sense_hit_out) & ~$past(pwdata) | $past(criterion_hit))) else $error("clear");
    chk_hit_keep: assert property (!hw |=> sense_hit_out ==
        ($past(sense_hit_out) | $past(criterion_hit))) else $error("flags");
    chk_dir_read: assert property (rd && dw == 0 && paddr[11:3] == 9'hA3 |->
        prdata == pin_dir_out) else $error("dir read");
    chk_hit_read: assert property (rd && paddr == 12'h520 |-> prdata == sense_hit_out)
        else $error("flag read");
endmodule
`default_nettype wire

// file: gpio_direction_and_sense_flags_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Bench
module gpio_direction_and_sense_flags_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, criterion_hit = 32'h0, prdata, pin_dir_out, sense_hit_out, q;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, e;
    int n_errors = 0, total_checks = 0, cyc = 0;
    gdsf_gpio_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .criterion_hit(criterion_hit),
        .pin_dir_out(pin_dir_out), .sense_hit_out(sense_hit_out));
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", nm, ex, got);
        end
    endtask
    // Ends just after the sampling edge; the next call waits an edge first
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, q);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc("set view", 12'h518, 32'h0);
        rdc("flags", 12'h520, 32'h0);
        $display("test reset done");
        apb(1'b1, 12'h518, 32'hC000_0001);
        chk("no error", 32'h0, {31'h0, e});
        chk("ready", 32'h1, {31'h0, pready});
        rdc("clear view", 12'h51C, 32'hC000_0001);
        apb(1'b1, 12'h518, 32'h0000_0010);
        rdc("set view", 12'h518, 32'hC000_0011);
        apb(1'b1, 12'h51C, 32'h8000_0001);
        rdc("clear view", 12'h51C, 32'h4000_0010);
        chk("dir pins", 32'h4000_0010, pin_dir_out);
        $display("test direction done");
        @(posedge pclk) criterion_hit <= 32'h8000_0003;
        @(posedge pclk) criterion_hit <= 32'h0;
        rdc("flags", 12'h520, 32'h8000_0003);
        chk("flag pins", 32'h8000_0003, sense_hit_out);
        apb(1'b1, 12'h520, 32'h0000_0001);
        rdc("flags", 12'h520, 32'h8000_0002);
        criterion_hit <= 32'h2;
        apb(1'b1, 12'h520, 32'h0000_0002);
        criterion_hit <= 32'h0;
        rdc("flags", 12'h520, 32'h8000_0002);
        apb(1'b1, 12'h520, 32'hFFFF_FFFF);
        rdc("flags", 12'h520, 32'h0);
        apb(1'b0, 12'h524, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        pstrb <= 4'h1;
        apb(1'b1, 12'h518, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        rdc("lane gate", 12'h518, 32'h4000_00FF);
        $display("test flags done");
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("dir in reset", 32'h0, pin_dir_out);
        presetn <= 1'b1;
        rdc("set view", 12'h518, 32'h0);
        $display("test reset again done");
        wrap_up;
    end
endmodule
bind gdsf_gpio_regs gdsf_regs_chk #(.PINS(PINS)) i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
    .criterion_hit(criterion_hit), .pin_dir_out(pin_dir_out), .sense_hit_out(sense_hit_out));
`default_nettype wire
